// file: shared/gsra_defines.svh
/*
 * Constants of the serial register-access port: bus address, register
 * indices touched by the port, control bit position.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef GSRA_DEFINES_SVH
`define GSRA_DEFINES_SVH

// ****************************************************************
// Two-wire bus address
// ****************************************************************
`define GSRA_ADDR_UPPER    6'h10
`define GSRA_ADDR_W        7

// ****************************************************************
// Register indices and reset value of the image
// ****************************************************************
`define GSRA_IDX_W         7
`define GSRA_IDX_STATUS    7'h00
`define GSRA_IDX_LAST_AXIS 7'h06
`define GSRA_IDX_CTRL0     7'h0d
`define GSRA_CTRL0_3W_BIT  0
`define GSRA_REG_RESET     8'h00

// ****************************************************************
// Frame layout
// ****************************************************************
`define GSRA_BYTE_W        8
`define GSRA_LAST_BIT      3'h7
`define GSRA_SYNC_W        5

`endif

// file: shared/gsra_pkg.sv
/*
 * Types of the serial register-access port.
 * Assumes gsra_defines.svh is on the include path.
 */
`include "gsra_defines.svh"

package gsra_pkg;

    // Register index and data carried together
    typedef struct packed {
        logic [`GSRA_IDX_W-1:0]  addr;
        logic [`GSRA_BYTE_W-1:0] data;
    } gsra_wr_t;

    // Two-wire slave sequence
    typedef enum logic [3:0] {
        GSRA_I2C_IDLE,
        GSRA_I2C_ADDR,
        GSRA_I2C_ADDR_ACK,
        GSRA_I2C_INDEX,
        GSRA_I2C_INDEX_ACK,
        GSRA_I2C_WDATA,
        GSRA_I2C_WDATA_ACK,
        GSRA_I2C_RDATA,
        GSRA_I2C_RACK,
        GSRA_I2C_IGNORE
    } gsra_i2c_state_t;

endpackage

// file: src/gsra_sync.sv
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level that is stable for several clocks.
 */
`timescale 1ns/1ps

module gsra_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// file: src/gsra_port.sv
/*
 * Serial register-access port: two-wire slave on ref_clk by oversampling,
 * four/three-wire serial slave on the link clock, and the register image.
 * Assumes the core pushes its read-only values through upd_* and watches
 * wr_* for host writes; link clock is the shared clock pin itself.
 */
`timescale 1ns/1ps
`include "gsra_defines.svh"

module gsra_port #(
    parameter int NUM_REGS = 128
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // Shared clock pin, also the link clock
    input  wire logic              serial_clk,
    input  wire logic              chip_select_n,
    // Data pin (two-wire data / master-out / three-wire data)
    input  wire logic              data_pin_in,
    output logic                   data_pin_out,
    output logic                   data_pin_oe,
    // Select pin (address select / master-in)
    input  wire logic              address_select_pin,
    output logic                   miso_out,
    output logic                   miso_oe,
    // Core side
    input  wire logic              upd_valid,
    input  wire gsra_pkg::gsra_wr_t upd_word,
    output logic                   wr_strobe,
    output gsra_pkg::gsra_wr_t     wr_word
);
    import gsra_pkg::*;

    // Image must hold the axis block and the control byte, and fit the index
    if (NUM_REGS < 16 || NUM_REGS > (1 << `GSRA_IDX_W))
    begin : g_bad_regs
        $error("gsra_port: NUM_REGS out of range");
    end

    // ****************************************************************
    // Register image
    // ****************************************************************
    logic [`GSRA_BYTE_W-1:0] regs [NUM_REGS];
    logic                    host_wr;
    gsra_wr_t                host_word;
    logic                    three_wire_enable;

    // Read pointer step with wrap back to status
    function automatic logic [`GSRA_IDX_W-1:0] rd_step(input logic [`GSRA_IDX_W-1:0] i);
        rd_step = (i == `GSRA_IDX_LAST_AXIS) ? `GSRA_IDX_STATUS : i + 7'h01;
    endfunction

    // Core update first, so a host write to the same index wins
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs[i] <= `GSRA_REG_RESET;
        end
        else
        begin
            if (upd_valid)
                regs[upd_word.addr] <= upd_word.data;
            if (host_wr)
                regs[host_word.addr] <= host_word.data;
        end
    end

    // Notify the core of every host write
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_strobe <= 1'b0;
            wr_word   <= '0;
        end
        else
        begin
            wr_strobe <= host_wr;
            if (host_wr)
                wr_word <= host_word; // Held between strobes
        end
    end

    // ****************************************************************
    // Pin synchronisers on ref_clk
    // ****************************************************************
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic cs_s;
    logic spi_tgl_s;
    logic spi_tgl;
    logic [`GSRA_SYNC_W-1:0] sync_q;

    gsra_sync #(.WIDTH(`GSRA_SYNC_W)) u_ref_sync (
        .clk   (ref_clk),
        .rst_n (nrst),
        .d     ({serial_clk, data_pin_in, address_select_pin, chip_select_n, spi_tgl}),
        .q     (sync_q)
    );
    assign {scl_s, sda_s, sel_s, cs_s, spi_tgl_s} = sync_q;

    // ****************************************************************
    // Two-wire slave
    // ****************************************************************
    gsra_i2c_state_t         st;
    gsra_i2c_state_t         next_st;
    logic                    scl_q, sda_q, tgl_q;
    logic [2:0]              bcnt, next_bcnt;
    logic [`GSRA_BYTE_W-1:0] rxsh, next_rxsh;
    logic [`GSRA_BYTE_W-1:0] txsh, next_txsh;
    logic [`GSRA_IDX_W-1:0]  ptr, next_ptr;
    logic                    acking, next_acking;
    logic                    sda_oe, next_sda_oe;
    logic                    i2c_wr;
    logic [`GSRA_BYTE_W-1:0] rx_byte;
    logic                    scl_rise, scl_fall, bus_open_condition, bus_close_condition;

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign bus_open_condition  = scl_s & scl_q & sda_q & ~sda_s;
    assign bus_close_condition = scl_s & scl_q & ~sda_q & sda_s;
    assign rx_byte = {rxsh[6:0], sda_s};

    // Next state of the two-wire sequence; SCL is only ever sampled, never driven
    always_comb
    begin
        next_st     = st;
        next_bcnt   = bcnt;
        next_rxsh   = rxsh;
        next_txsh   = txsh;
        next_ptr    = ptr;
        next_acking = acking;
        next_sda_oe = sda_oe;
        i2c_wr      = 1'b0;
        if (!cs_s)
        begin
            next_st     = GSRA_I2C_IDLE;
            next_sda_oe = 1'b0;
            next_acking = 1'b0;
        end
        else if (bus_open_condition)
        begin
            next_st     = GSRA_I2C_ADDR;
            next_bcnt   = 3'h0;
            next_sda_oe = 1'b0;
            next_acking = 1'b0;
        end
        else if (bus_close_condition)
        begin
            next_st     = GSRA_I2C_IDLE;
            next_sda_oe = 1'b0;
            next_acking = 1'b0;
        end
        else
        begin
            unique case (st)
                GSRA_I2C_IDLE, GSRA_I2C_IGNORE:
                    next_sda_oe = 1'b0;
                GSRA_I2C_ADDR, GSRA_I2C_INDEX, GSRA_I2C_WDATA:
                    if (scl_rise)
                    begin
                        next_rxsh = rx_byte;
                        next_bcnt = bcnt + 3'h1;
                        if (bcnt == `GSRA_LAST_BIT)
                        begin
                            unique case (st)
                                GSRA_I2C_ADDR:
                                    if (rx_byte[7:1] == {`GSRA_ADDR_UPPER, sel_s})
                                        next_st = GSRA_I2C_ADDR_ACK;
                                    else
                                        next_st = GSRA_I2C_IGNORE;
                                GSRA_I2C_INDEX:
                                begin
                                    next_ptr = rx_byte[6:0];
                                    next_st  = GSRA_I2C_INDEX_ACK;
                                end
                                default:
                                    next_st = GSRA_I2C_WDATA_ACK;
                            endcase
                        end
                    end
                GSRA_I2C_ADDR_ACK, GSRA_I2C_INDEX_ACK, GSRA_I2C_WDATA_ACK:
                    if (scl_fall && !acking)
                    begin
                        next_sda_oe = 1'b1;
                        next_acking = 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        next_acking = 1'b0;
                        next_sda_oe = 1'b0;
                        next_bcnt   = 3'h0;
                        if (st == GSRA_I2C_ADDR_ACK && rxsh[0])
                        begin
                            next_sda_oe = ~regs[ptr][7];
                            next_txsh   = {regs[ptr][6:0], 1'b0};
                            next_st     = GSRA_I2C_RDATA;
                        end
                        else if (st == GSRA_I2C_WDATA_ACK)
                        begin
                            i2c_wr   = 1'b1;
                            next_ptr = ptr + 7'h01;
                            next_st  = GSRA_I2C_WDATA;
                        end
                        else if (st == GSRA_I2C_ADDR_ACK)
                            next_st = GSRA_I2C_INDEX;
                        else
                            next_st = GSRA_I2C_WDATA;
                    end
                GSRA_I2C_RDATA:
                    if (scl_fall)
                    begin
                        next_sda_oe = ~txsh[7];
                        next_txsh   = {txsh[6:0], 1'b0};
                    end
                    else if (scl_rise)
                    begin
                        next_bcnt = bcnt + 3'h1;
                        if (bcnt == `GSRA_LAST_BIT)
                            next_st = GSRA_I2C_RACK;
                    end
                GSRA_I2C_RACK:
                    if (scl_fall)
                        next_sda_oe = 1'b0;
                    else if (scl_rise && !sda_s)
                    begin
                        next_ptr  = rd_step(ptr);
                        next_txsh = regs[rd_step(ptr)];
                        next_bcnt = 3'h0;
                        next_st   = GSRA_I2C_RDATA;
                    end
                    else if (scl_rise)
                        next_st = GSRA_I2C_IGNORE;
            endcase
        end
    end

    // Two-wire state registers
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st     <= GSRA_I2C_IDLE;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            tgl_q  <= 1'b0;
            bcnt   <= 3'h0;
            rxsh   <= '0;
            txsh   <= '0;
            ptr    <= '0;
            acking <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            st     <= next_st;
            scl_q  <= scl_s;
            sda_q  <= sda_s;
            tgl_q  <= spi_tgl_s;
            bcnt   <= next_bcnt;
            rxsh   <= next_rxsh;
            txsh   <= next_txsh;
            ptr    <= next_ptr;
            acking <= next_acking;
            sda_oe <= next_sda_oe;
        end
    end

    // ****************************************************************
    // Link-clock serial slave
    // ****************************************************************
    logic                    spi_rst_n;
    logic                    first, next_first;
    logic                    rw, next_rw;
    logic [2:0]              sbit, next_sbit;
    logic [`GSRA_BYTE_W-1:0] ssh, next_ssh;
    logic [`GSRA_IDX_W-1:0]  sidx, next_sidx;
    gsra_wr_t                spi_word, next_spi_word;
    logic                    next_spi_tgl;
    logic [`GSRA_BYTE_W-1:0] s_byte;
    logic [`GSRA_BYTE_W-1:0] stx, next_stx;
    logic                    next_miso, next_miso_oe, next_dio, next_dio_oe;
    logic                    dio_oe;
    logic                    sync_3w;

    // Chip select high holds the link frame state and output drivers in reset between frames
    assign spi_rst_n = nrst & ~chip_select_n;
    assign s_byte    = {ssh[6:0], data_pin_in};

    // Control bit brought into the link domain
    gsra_sync #(.WIDTH(1)) u_link_sync (
        .clk   (serial_clk),
        .rst_n (nrst),
        .d     (regs[`GSRA_IDX_CTRL0][`GSRA_CTRL0_3W_BIT]),
        .q     (sync_3w)
    );
    assign three_wire_enable = sync_3w;

    // Rising-edge capture of command, index and write data
    always_comb
    begin
        next_first    = first;
        next_rw       = rw;
        next_sbit     = sbit + 3'h1;
        next_ssh      = s_byte;
        next_sidx     = sidx;
        next_spi_word = spi_word;
        next_spi_tgl  = spi_tgl;
        if (sbit == `GSRA_LAST_BIT)
        begin
            if (first)
            begin
                next_rw    = s_byte[7];
                next_sidx  = s_byte[6:0];
                next_first = 1'b0;
            end
            else if (!rw)
            begin
                next_spi_word = '{addr: sidx, data: s_byte};
                next_spi_tgl  = ~spi_tgl;
                next_sidx     = sidx + 7'h01;
            end
            else
                next_sidx = rd_step(sidx);
        end
    end

    // Frame state, cleared by chip select
    always_ff @(posedge serial_clk or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            first <= 1'b1;
            rw    <= 1'b0;
            sbit  <= 3'h0;
            ssh   <= '0;
            sidx  <= '0;
        end
        else
        begin
            first <= next_first;
            rw    <= next_rw;
            sbit  <= next_sbit;
            ssh   <= next_ssh;
            sidx  <= next_sidx;
        end
    end

    // Write word and toggle survive chip select so the crossing is clean
    always_ff @(posedge serial_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            spi_word <= '0;
            spi_tgl  <= 1'b0;
        end
        else
        begin
            spi_word <= next_spi_word;
            spi_tgl  <= next_spi_tgl;
        end
    end

    // Falling-edge shift out; image is read live, a byte changing mid-read may tear
    always_comb
    begin
        next_stx     = {stx[6:0], 1'b0};
        next_miso    = stx[7];
        next_dio     = stx[7];
        next_miso_oe = miso_oe;
        next_dio_oe  = dio_oe;
        if (sbit == 3'h0 && !first && rw)
        begin
            next_stx     = {regs[sidx][6:0], 1'b0};
            next_miso    = regs[sidx][7];
            next_dio     = regs[sidx][7];
            next_miso_oe = ~three_wire_enable;
            next_dio_oe  = three_wire_enable;
        end
    end

    // Output drivers of the link domain
    always_ff @(negedge serial_clk or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            stx          <= '0;
            miso_out     <= 1'b0;
            miso_oe      <= 1'b0;
            data_pin_out <= 1'b0;
            dio_oe       <= 1'b0;
        end
        else
        begin
            stx          <= next_stx;
            miso_out     <= next_miso;
            miso_oe      <= next_miso_oe;
            data_pin_out <= next_dio;
            dio_oe       <= next_dio_oe;
        end
    end

    // Data pin enable: two-wire pull-down or three-wire drive, never both by chip select
    assign data_pin_oe = sda_oe | dio_oe;

    // ****************************************************************
    // Host write merge on ref_clk
    // ****************************************************************
    always_comb
    begin
        host_wr   = i2c_wr | (spi_tgl_s ^ tgl_q);
        host_word = i2c_wr ? '{addr: ptr, data: rxsh} : spi_word;
    end

endmodule

// file: test/gsra_port_chk.sv
/* Concurrent checks on the port pins and the host-write outputs.
   Assumes a bind onto gsra_port from the bench top. */
`timescale 1ns/1ps
module gsra_port_chk (
    // Clocks and reset
    input wire logic               ref_clk,
    input wire logic               nrst,
    input wire logic               serial_clk,
    // Pins
    input wire logic               chip_select_n,
    input wire logic               data_pin_in,
    input wire logic               data_pin_out,
    input wire logic               data_pin_oe,
    input wire logic               miso_oe,
    // Core side
    input wire logic               wr_strobe,
    input wire gsra_pkg::gsra_wr_t wr_word
);
    import gsra_pkg::*;
    logic [4:0] rises;
    logic       rd;
    // Rises and direction of a frame; saturates so long bursts stay legal
    always_ff @(posedge serial_clk or posedge chip_select_n or negedge nrst)
    begin
        if (!nrst || chip_select_n)
        begin
            rises <= 5'h0;
            rd    <= 1'b0;
        end
        else
        begin
            rises <= (rises == 5'h10) ? rises : rises + 5'h1;
            if (rises == 5'h0)
                rd <= data_pin_in;
        end
    end
    sequence s_cmd_done;
        rises == 5'h8;
    endsequence
    // ****************
    // Two-wire pins and host writes
    // ****************
    chk_sel_input_only:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            chip_select_n && $past(chip_select_n) |-> !miso_oe)
        else $error("select pin driven");
    chk_sda_pull_low:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            chip_select_n && $past(chip_select_n, 2) && data_pin_oe |-> !data_pin_out)
        else $error("data pin driven high");
    chk_sda_scl_low:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            chip_select_n && $past(chip_select_n) && $changed(data_pin_oe) |-> !serial_clk)
        else $error("data pin moved with clock high");
    chk_strobe_single:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            wr_strobe |=> !wr_strobe)
        else $error("strobe too long");
    chk_word_held:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            !$stable(wr_word) |-> wr_strobe)
        else $error("write word moved alone");
    // ****************
    // Serial frames
    // ****************
    chk_write_quiet:
        assert property (@(posedge serial_clk) disable iff (!nrst || chip_select_n)
            rises != 5'h0 && !rd |-> !miso_oe && !data_pin_oe)
        else $error("drive in write frame");
    chk_drive_after_cmd:
        assert property (@(posedge serial_clk) disable iff (!nrst || chip_select_n)
            miso_oe || data_pin_oe |-> rises >= 5'h8)
        else $error("drive before command end");
    chk_miso_turn:
        assert property (@(posedge serial_clk) disable iff (!nrst || chip_select_n)
            $rose(miso_oe) |-> s_cmd_done)
        else $error("master-in turned late");
    chk_dio_turn:
        assert property (@(posedge serial_clk) disable iff (!nrst || chip_select_n)
            $rose(data_pin_oe) |-> s_cmd_done)
        else $error("data pin turned late");
    chk_one_driver:
        assert property (@(posedge serial_clk) disable iff (!nrst || chip_select_n)
            !(miso_oe && data_pin_oe))
        else $error("both data pins driven");
endmodule

// file: test/gsra_host_model.sv
/* Host master: two-wire at about 190 kHz and serial at 12.5 MHz.
   Assumes the bench resolves the data wire and the select wire. */
`timescale 1ns/1ps
module gsra_host_model (
    // Pins driven
    output logic     serial_clk,
    output logic     chip_select_n,
    output logic     host_oe,
    output logic     host_d,
    // Resolved wires
    input wire logic data_wire,
    input wire logic sel_wire
);
    localparam int Q = 1300; // Quarter bit, keeps below 400 kHz
    localparam int H = 40;
    // Idle bus; two link edges inside reset for its synchroniser
    initial
    begin
        serial_clk    = 1'b1;
        chip_select_n = 1'b1;
        host_oe       = 1'b0;
        host_d        = 1'b0;
        repeat (2)
        begin
            #H serial_clk = 1'b0;
            #H serial_clk = 1'b1;
        end
    end
    // Open drain: the host only ever pulls low
    task automatic i2c_bit(input logic b, output logic r);
        host_d  = 1'b0;
        host_oe = !b;
        #Q serial_clk = 1'b1;
        #Q r = data_wire;
        #Q serial_clk = 1'b0;
        #Q;
    endtask
    task automatic i2c_start();
        host_oe = 1'b0;
        host_d  = 1'b0;
        #Q serial_clk = 1'b1;
        #Q host_oe = 1'b1;
        #Q serial_clk = 1'b0;
        #Q;
    endtask
    task automatic i2c_stop();
        host_d  = 1'b0;
        host_oe = 1'b1;
        #Q serial_clk = 1'b1;
        #Q host_oe = 1'b0;
        #Q;
    endtask
    task automatic i2c_byte(input logic [7:0] b, input logic ab, output logic [7:0] r,
                            output logic a);
        for (int i = 7; i >= 0; i--)
            i2c_bit(b[i], r[i]);
        i2c_bit(ab, a);
    endtask
    // Drive on the fall, sample on the rise
    task automatic spi_byte(input logic [7:0] b, input logic rel, input logic w3,
                            output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            host_oe = !rel;
            host_d  = b[i];
            #H serial_clk = 1'b1;
            r[i] = w3 ? data_wire : sel_wire;
            #H serial_clk = 1'b0;
        end
    endtask
    task automatic spi_cs(input logic v);
        serial_clk = 1'b0;
        #H chip_select_n = v;
        #H;
    endtask
endmodule

// file: test/gsra_port_test.sv
/* Self-checking bench of gsra_port with a host model and an image model.
   Assumes the checker and the host model are compiled first. */
`timescale 1ns/1ps
module gsra_port_test;
    import gsra_pkg::*;
    logic        ref_clk, nrst, sel, upd_valid, data_wire, sel_wire;
    logic        serial_clk, chip_select_n, host_oe, host_d;
    logic        data_pin_out, data_pin_oe, miso_out, miso_oe, wr_strobe;
    gsra_wr_t    upd_word, wr_word;
    int          error_cnt, total_checks, cyc;
    integer      seed = 32'hf5a6da65;
    logic [7:0]  img [128] = '{default: 8'h00};
    logic [14:0] exp_q [$];
    // Pull-up on data; a released master-in shows a changing level
    assign data_wire = data_pin_oe ? data_pin_out : (host_oe ? host_d : 1'b1);
    assign sel_wire  = chip_select_n ? sel : (miso_oe ? miso_out : ref_clk);
    gsra_port gsra_port_i (.ref_clk(ref_clk), .nrst(nrst), .serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .data_pin_in(data_wire), .data_pin_out(data_pin_out),
        .data_pin_oe(data_pin_oe), .address_select_pin(sel_wire), .miso_out(miso_out),
        .miso_oe(miso_oe), .upd_valid(upd_valid), .upd_word(upd_word),
        .wr_strobe(wr_strobe), .wr_word(wr_word));
    gsra_host_model host_i (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
        .host_oe(host_oe), .host_d(host_d), .data_wire(data_wire), .sel_wire(sel_wire));
    always #50 ref_clk = ~ref_clk;
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Host writes land in the image at once; the strobe is awaited later
    task automatic wr_exp(input int p, input logic [7:0] d);
        exp_q.push_back({p[6:0], d});
        img[p] = d;
    endtask
    function automatic int rd_next(input int p);
        return (p == 6) ? 0 : p + 1;
    endfunction
    task automatic send(input logic [7:0] b, input logic ack);
        logic [7:0] r;
        logic       a;
        host_i.i2c_byte(b, 1'b1, r, a);
        check({14'h0, a}, {14'h0, ack});
    endtask
    task automatic i2c_xfer(input logic rw, input int p, input int n);
        logic [7:0] r;
        logic       a;
        host_i.i2c_start();
        send({6'h10, sel, 1'b0}, 1'b0);
        send(p[7:0], 1'b0);
        if (rw)
        begin
            host_i.i2c_start();
            send({6'h10, sel, 1'b1}, 1'b0);
        end
        for (int k = 0; k < n; k++)
        begin
            if (rw)
            begin
                host_i.i2c_byte(8'hff, k == n - 1, r, a);
                check({7'h0, r}, {7'h0, img[p]});
                p = rd_next(p);
            end
            else
            begin
                r = 8'($random(seed));
                wr_exp(p, r);
                send(r, 1'b0);
                p++;
            end
        end
        host_i.i2c_stop();
    endtask
    task automatic spi(input logic rw, input int p, input int n, input logic w3,
                       input logic [7:0] d0);
        logic [7:0] r;
        host_i.spi_cs(1'b0);
        host_i.spi_byte({rw, p[6:0]}, 1'b0, w3, r);
        for (int k = 0; k < n; k++)
        begin
            if (rw)
            begin
                host_i.spi_byte(8'h00, w3, w3, r);
                check({7'h0, r}, {7'h0, img[p]});
                p = rd_next(p);
            end
            else
            begin
                wr_exp(p, d0 + k[7:0]);
                host_i.spi_byte(d0 + k[7:0], 1'b0, w3, r);
                p++;
            end
        end
        host_i.spi_cs(1'b1);
        #640;
    endtask
    // Every host write seen against the expected queue
    always @(negedge ref_clk)
        if (wr_strobe === 1'b1)
            check(wr_word, exp_q.size() > 0 ? exp_q.pop_front() : 15'h7fff);
    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: run too long", $time);
            report_and_stop();
        end
    end
    initial
    begin
        ref_clk   = 1'b0;
        nrst      = 1'b0;
        upd_valid = 1'b0;
        upd_word  = '0;
        sel       = 1'b0;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        sel  = seed[0];
        for (int i = 0; i <= 6; i++)
        begin
            @(negedge ref_clk);
            upd_valid = 1'b1;
            upd_word  = {i[6:0], 8'($random(seed))};
            img[i]    = upd_word.data;
            @(negedge ref_clk);
            upd_valid = 1'b0;
        end
        host_i.i2c_start();
        send({6'h10, !sel, 1'b0}, 1'b1);
        send(8'h00, 1'b1);
        host_i.i2c_stop();
        i2c_xfer(1'b0, 8'h10, 3);
        i2c_xfer(1'b1, 8'h10, 3);
        i2c_xfer(1'b1, 5, 3);
        sel = !sel;
        i2c_xfer(1'b1, 6, 2);
        spi(1'b0, 8'h20, 2, 1'b0, 8'($random(seed)));
        spi(1'b1, 8'h20, 2, 1'b0, 8'h00);
        spi(1'b1, 6, 2, 1'b0, 8'h00);
        spi(1'b0, 8'h0d, 1, 1'b0, 8'h01);
        spi(1'b1, 1, 2, 1'b1, 8'h00);
        spi(1'b0, 8'h0d, 1, 1'b1, 8'h00);
        spi(1'b1, 8'h0d, 1, 1'b0, 8'h00);
        check(15'(exp_q.size()), 15'h0);
        report_and_stop();
    end
endmodule
bind gsra_port gsra_port_chk chk_i (.ref_clk(ref_clk), .nrst(nrst),
    .serial_clk(serial_clk), .chip_select_n(chip_select_n), .data_pin_in(data_pin_in),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .miso_oe(miso_oe),
    .wr_strobe(wr_strobe), .wr_word(wr_word));
